// ===== inc/src_pkg.sv
// Package of constants and types for the system reset combiner
package src_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int MIN_HOLD_NS = 100;
    localparam int MIN_HOLD_CYCLES = (MIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CAUSE_W = 12;
    localparam int SCRATCH_WORDS = 4;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CAUSE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_SCRATCH = 4'hC;

    // ----------------------------------------
    // Fields of the cause register
    // ----------------------------------------
    localparam int BIT_POWER_ON = 0;
    localparam int BIT_BROWNOUT = 1;
    localparam int BIT_WAKE_IDLE = 2;
    localparam int BIT_WAKE_SLEEP = 3;
    localparam int BIT_WATCHDOG = 4;
    localparam int BIT_WDOG_SW_ENABLE = 5;
    localparam int BIT_SW_INSTR = 6;
    localparam int BIT_EXT_PIN = 7;
    localparam int BIT_CONFIG_MISMATCH = 8;
    localparam int BIT_ILLEGAL_OPCODE = 9;
    localparam int BIT_UNINIT_WREG = 10;
    localparam int BIT_TRAP_CONFLICT = 11;

    // ----------------------------------------
    // Synchronised request sources, by index
    // ----------------------------------------
    localparam int NUM_SRC = 8;
    localparam int SRC_EXT_PIN = 0;
    localparam int SRC_SW_INSTR = 1;
    localparam int SRC_WATCHDOG = 2;
    localparam int SRC_BROWNOUT = 3;
    localparam int SRC_CONFIG_MISMATCH = 4;
    localparam int SRC_TRAP_CONFLICT = 5;
    localparam int SRC_ILLEGAL_OPCODE = 6;
    localparam int SRC_UNINIT_WREG = 7;
    localparam int SRC_CAUSE_POS [NUM_SRC] = '{
        BIT_EXT_PIN, BIT_SW_INSTR, BIT_WATCHDOG, BIT_BROWNOUT,
        BIT_CONFIG_MISMATCH, BIT_TRAP_CONFLICT, BIT_ILLEGAL_OPCODE, BIT_UNINIT_WREG};

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 12'h003;
    localparam logic [CAUSE_W-1:0] IRQ_STATUS_RESET = 12'h000;
    localparam logic [CAUSE_W-1:0] IRQ_MASK_RESET = 12'h000;
    localparam logic [CAUSE_W-1:0] HW_ONLY_IRQ = 12'hFDF;

    // ----------------------------------------
    // Bus answer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ANSWER = 2'b10
    } src_bus_e;

endpackage

// ===== inc/src_sync_if.sv
// Interface carrying raw and synchronised reset requests
interface src_sync_if #(parameter int N = 8);
    logic [N-1:0] raw;
    logic [N-1:0] synced;
    modport syncer (input raw, output synced);
    modport user (output raw, input synced);
endinterface

// ===== hw/src_sync.sv
// Two-flop synchronisers for the reset request inputs
module src_sync #(
    parameter int N = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    src_sync_if.syncer bus
);
    // ----------------------------------------
    // One synchroniser per request
    // ----------------------------------------
    // First stage feeds only the second stage
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_sync
            logic meta;
            logic stable;
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    meta <= 1'b0;
                    stable <= 1'b0;
                end else if (i_ce) begin
                    meta <= bus.raw[g];
                    stable <= meta;
                end
            end
            assign bus.synced[g] = stable;
        end
    endgenerate
endmodule // src_sync

// ===== hw/src_top.sv
// Reset combiner with cause register and Avalon-MM register slave
// ----------------------------------------
// ----------------------------------------
//
// Added by the designer: the register addresses and register access over Avalon-MM.
module src_top #(
    parameter int HOLD_CYCLES = src_pkg::MIN_HOLD_CYCLES,
    parameter int SCRATCH_WORDS = src_pkg::SCRATCH_WORDS
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_external_pin_reset,
    input wire logic i_software_reset_instruction,
    input wire logic i_watchdog_reset,
    input wire logic i_brownout_reset,
    input wire logic i_config_mismatch_reset,
    input wire logic i_trap_conflict_reset,
    input wire logic i_illegal_opcode_reset,
    input wire logic i_uninit_wreg_reset,
    input wire logic i_wake_from_idle,
    input wire logic i_wake_from_sleep,
    input wire logic [src_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [src_pkg::DATA_W-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [src_pkg::DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_master_reset,
    output logic o_watchdog_sw_enable,
    output logic o_irq
);
    import src_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYCLES);
    localparam logic [HOLD_W-1:0] HOLD_ZERO = '0;

    src_sync_if #(.N(NUM_SRC)) req_if ();

    logic [HOLD_W-1:0] hold_cnt;
    logic [HOLD_W-1:0] next_hold_cnt;
    logic next_master_reset;
    logic [CAUSE_W-1:0] cause;
    logic [CAUSE_W-1:0] next_cause;
    logic [CAUSE_W-1:0] irq_status;
    logic [CAUSE_W-1:0] next_irq_status;
    logic [CAUSE_W-1:0] irq_mask;
    logic [CAUSE_W-1:0] next_irq_mask;
    logic [DATA_W-1:0] scratch [SCRATCH_WORDS];
    logic [DATA_W-1:0] next_readdata;
    logic [CAUSE_W-1:0] reported;
    src_bus_e state;
    src_bus_e next_state;

    wire [NUM_SRC-1:0] src_req;
    wire any_request;
    wire [CAUSE_W-1:0] hw_set;
    wire [CAUSE_W-1:0] irq_set;
    wire [DATA_W-1:0] byte_mask;
    wire bus_req;
    wire take;
    wire do_read;
    wire do_write;
    wire hit_cause;
    wire hit_irq_status;
    wire hit_irq_mask;
    wire hit_scratch;
    wire [1:0] scratch_idx;
    wire [DATA_W-1:0] cause_word;
    wire [DATA_W-1:0] irq_status_word;
    wire [DATA_W-1:0] irq_mask_word;
    wire [DATA_W-1:0] scratch_word;
    wire [CAUSE_W-1:0] wr_cause;
    wire [CAUSE_W-1:0] wr_mask;
    wire next_irq;

    // ----------------------------------------
    // Request synchronisers
    // ----------------------------------------
    // Supervisory and pin requests come from outside this clock domain
    assign req_if.raw[SRC_EXT_PIN] = i_external_pin_reset;
    assign req_if.raw[SRC_SW_INSTR] = i_software_reset_instruction;
    assign req_if.raw[SRC_WATCHDOG] = i_watchdog_reset;
    assign req_if.raw[SRC_BROWNOUT] = i_brownout_reset;
    assign req_if.raw[SRC_CONFIG_MISMATCH] = i_config_mismatch_reset;
    assign req_if.raw[SRC_TRAP_CONFLICT] = i_trap_conflict_reset;
    assign req_if.raw[SRC_ILLEGAL_OPCODE] = i_illegal_opcode_reset;
    assign req_if.raw[SRC_UNINIT_WREG] = i_uninit_wreg_reset;

    src_sync #(
        .N(NUM_SRC)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .bus(req_if.syncer)
    );

    assign src_req = req_if.synced;

    // ----------------------------------------
    // Master reset combine
    // ----------------------------------------
    // Power-on acts through the asynchronous reset of the flops below
    assign any_request = |src_req;

    // A short request is stretched so every receiver sees a full reset
    // Trade-off: every request costs HOLD_CYCLES-1 extra edges of reset
    always_comb begin
        next_hold_cnt = hold_cnt;
        if (any_request) begin
            next_hold_cnt = HOLD_LOAD;
        end else if (hold_cnt != HOLD_ZERO) begin
            next_hold_cnt = hold_cnt - 1'b1;
        end
    end

    assign next_master_reset = any_request || (next_hold_cnt != HOLD_ZERO);

    // Power-on starts a full stretch, so the first release is timed like any other
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hold_cnt <= HOLD_LOAD;
        end else if (i_ce) begin
            hold_cnt <= next_hold_cnt;
        end
    end

    // Registered so every receiver leaves reset on the same edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_master_reset <= 1'b1;
        end else if (i_ce) begin
            o_master_reset <= next_master_reset;
        end
    end

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign bus_req = i_avs_read || i_avs_write;
    assign take = (state == ST_ANSWER);
    assign do_read = take && i_avs_read;
    assign do_write = take && i_avs_write;
    assign hit_cause = (i_avs_address == OFS_CAUSE);
    assign hit_irq_status = (i_avs_address == OFS_IRQ_STATUS);
    assign hit_irq_mask = (i_avs_address == OFS_IRQ_MASK);
    assign hit_scratch = (i_avs_address == OFS_SCRATCH);
    assign scratch_idx = 2'h0;

    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_be
            assign byte_mask[8*b +: 8] = {8{i_avs_byteenable[b]}};
        end
    endgenerate

    // Byte lanes merge the write data with the current word
    assign wr_cause = CAUSE_W'((i_avs_writedata & byte_mask) | (cause_word & ~byte_mask));
    assign wr_mask = CAUSE_W'((i_avs_writedata & byte_mask) | (irq_mask_word & ~byte_mask));

    assign cause_word = {{(DATA_W-CAUSE_W){1'b0}}, cause};
    assign irq_status_word = {{(DATA_W-CAUSE_W){1'b0}}, irq_status};
    assign irq_mask_word = {{(DATA_W-CAUSE_W){1'b0}}, irq_mask};
    assign scratch_word = scratch[scratch_idx];

    // Unmapped offsets read as zero and ignore writes
    assign next_readdata = hit_cause ? cause_word :
                           hit_irq_status ? irq_status_word :
                           hit_irq_mask ? irq_mask_word :
                           hit_scratch ? scratch_word : '0;

    // ----------------------------------------
    // Bus answer state machine
    // ----------------------------------------
    // Fixed latency: waitrequest drops on the first edge of a request
    // Trade-off: one wait state on every access buys registered outputs
    always_comb begin
        case (state)
            ST_IDLE: begin
                next_state = bus_req ? ST_ANSWER : ST_IDLE;
            end
            ST_ANSWER: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    // Registered answer keeps no combinational path back to the master
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_waitrequest <= 1'b1;
        end else if (i_ce) begin
            o_avs_waitrequest <= (next_state != ST_ANSWER);
        end
    end

    // Read data is captured one edge early and stands at the taking edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_readdata <= '0;
        end else if (i_ce && state == ST_IDLE && i_avs_read) begin
            o_avs_readdata <= next_readdata;
        end
    end

    // Remembers which status bits the read showed, so only those are cleared
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reported <= '0;
        end else if (i_ce && state == ST_IDLE && i_avs_read) begin
            reported <= hit_irq_status ? irq_status : '0;
        end
    end

    // ----------------------------------------
    // Cause register
    // ----------------------------------------
    generate
        for (b = 0; b < NUM_SRC; b++) begin : g_cause
            assign hw_set[SRC_CAUSE_POS[b]] = src_req[b];
        end
    endgenerate
    assign hw_set[BIT_POWER_ON] = 1'b0;
    // Wake events come from this clock domain and need no synchroniser
    assign hw_set[BIT_WAKE_IDLE] = i_wake_from_idle;
    assign hw_set[BIT_WAKE_SLEEP] = i_wake_from_sleep;
    assign hw_set[BIT_WDOG_SW_ENABLE] = 1'b0;

    // Hardware set wins over a software write in the same cycle
    // Limitation: a request still high keeps its bit set against any write
    always_comb begin
        next_cause = cause;
        if (do_write && hit_cause) begin
            next_cause = wr_cause;
        end
        next_cause = next_cause | hw_set;
    end

    // Only power-on resets the causes, so they survive a master reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cause <= CAUSE_RESET;
        end else if (i_ce) begin
            cause <= next_cause;
        end
    end

    // The cause register never feeds the master reset path
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_watchdog_sw_enable <= 1'b0;
        end else if (i_ce) begin
            o_watchdog_sw_enable <= next_cause[BIT_WDOG_SW_ENABLE];
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    assign irq_set = hw_set & HW_ONLY_IRQ;

    // Read clears only what the read reported; new events still stick
    always_comb begin
        next_irq_status = irq_status;
        if (do_read && hit_irq_status) begin
            next_irq_status = irq_status & ~reported;
        end
        next_irq_status = next_irq_status | irq_set;
    end

    always_comb begin
        next_irq_mask = irq_mask;
        if (do_write && hit_irq_mask) begin
            next_irq_mask = wr_mask;
        end
    end

    assign next_irq = |(next_irq_status & next_irq_mask);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_status <= IRQ_STATUS_RESET;
        end else if (i_ce) begin
            irq_status <= next_irq_status;
        end
    end

    // Mask has a defined value and is forced while reset holds
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_mask <= IRQ_MASK_RESET;
        end else if (i_ce) begin
            irq_mask <= o_master_reset ? IRQ_MASK_RESET : next_irq_mask;
        end
    end

    // Held low from the second cycle of a master reset so no handler runs on half-reset state
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= o_master_reset ? 1'b0 : next_irq;
        end
    end

    // ----------------------------------------
    // Scratch storage without reset value
    // ----------------------------------------
    // Unknown after power-on, kept through every other reset
    // Only word 0 is reachable through the single scratch offset
    always_ff @(posedge i_clk) begin
        if (i_ce && do_write && hit_scratch) begin
            scratch[scratch_idx] <= (i_avs_writedata & byte_mask) | (scratch_word & ~byte_mask);
        end
    end

endmodule // src_top

// ===== tb/src_req_model.sv
// Model of the reset request sources
module src_req_model (
    input wire logic i_clk,
    output logic [7:0] o_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_req = 8'h00;
    // Levels held across whole edges so the synchroniser catches them
    task automatic fire(input int idx, input int len);
        @(posedge i_clk);
        o_req[idx] <= 1'b1;
        repeat (len) @(posedge i_clk);
        o_req[idx] <= 1'b0;
    endtask
endmodule // src_req_model

// ===== tb/src_top_assertions.sv
// Port checker for the reset combiner
module src_top_assertions #(
    parameter int HOLD_CYCLES = 5
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_external_pin_reset,
    input wire logic i_software_reset_instruction,
    input wire logic i_watchdog_reset,
    input wire logic i_brownout_reset,
    input wire logic i_config_mismatch_reset,
    input wire logic i_trap_conflict_reset,
    input wire logic i_illegal_opcode_reset,
    input wire logic i_uninit_wreg_reset,
    input wire logic [src_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [src_pkg::DATA_W-1:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic o_master_reset,
    input wire logic o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic any_req;
    logic [3:0] quiet;
    assign any_req = i_external_pin_reset | i_software_reset_instruction | i_watchdog_reset | i_brownout_reset
        | i_config_mismatch_reset | i_trap_conflict_reset | i_illegal_opcode_reset | i_uninit_wreg_reset;
    // Saturates so a long quiet spell cannot wrap
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            quiet <= 4'h0;
        end else if (any_req) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    chk_req_asserts: assert property (any_req [*3] |=> o_master_reset)
        else $error("request did not raise master reset");
    chk_quiet_release: assert property (quiet > HOLD_CYCLES + 3 |-> !o_master_reset)
        else $error("master reset without request");
    chk_por_held: assert property ($rose(i_rst_n) |-> o_master_reset)
        else $error("master reset low at power-on release");
    chk_irq_in_reset: assert property (o_master_reset [*2] |-> !o_irq)
        else $error("irq during master reset");
    chk_ack_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("access not answered");
    chk_ack_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    chk_no_idle_ack: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
        else $error("answer without request");
    chk_upper_zero: assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:12] == 20'h0)
        else $error("upper read bits set");
    chk_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address[1:0] != 2'h0
        |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    cov_reset: cover property ($rose(o_master_reset));
    cov_read: cover property (i_avs_read && !o_avs_waitrequest);
    cov_irq: cover property ($rose(o_irq));
endmodule // src_top_assertions
bind src_top src_top_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) src_top_assertions_inst (.*);

// ===== tb/test_src_top.sv
// Self-checking bench for the reset combiner
module test_src_top;
    timeunit 1ns;
    timeprecision 1ps;
    import src_pkg::*;
    localparam int HOLD = 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic wk_i = 1'b0;
    logic wk_s = 1'b0;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] keep;
    logic [7:0] req;
    logic wait_req;
    logic mr;
    logic wd_en;
    logic irq;
    logic [11:0] hw_bits;
    logic [32:0] note;
    logic [32:0] notes[$];
    int err_total = 0;
    int tests_run = 0;
    always #10 clk = ~clk;
    src_top #(.HOLD_CYCLES(HOLD)) src_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
        .i_external_pin_reset(req[SRC_EXT_PIN]), .i_software_reset_instruction(req[SRC_SW_INSTR]),
        .i_watchdog_reset(req[SRC_WATCHDOG]), .i_brownout_reset(req[SRC_BROWNOUT]),
        .i_config_mismatch_reset(req[SRC_CONFIG_MISMATCH]), .i_trap_conflict_reset(req[SRC_TRAP_CONFLICT]),
        .i_illegal_opcode_reset(req[SRC_ILLEGAL_OPCODE]), .i_uninit_wreg_reset(req[SRC_UNINIT_WREG]),
        .i_wake_from_idle(wk_i), .i_wake_from_sleep(wk_s), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_req), .o_master_reset(mr), .o_watchdog_sw_enable(wd_en), .o_irq(irq));
    src_req_model src_req_model_inst (.i_clk(clk), .o_req(req));
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    // Reads leave a note; bit 32 says whether the data is checked
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [32:0] n_in);
        int n;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        if (!w) notes.push_back(n_in);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        rd <= 1'b0;
        wr <= 1'b0;
        chk(wait_req, 1'b0, "bus timeout");
        if (wait_req !== 1'b0) end_sim();
    endtask
    task automatic wait_mr(input logic v);
        int n;
        for (n = 0; n < 100 && mr !== v; n++) @(posedge clk);
        chk(mr, v, "master reset level");
        if (mr !== v) end_sim();
    endtask
    always @(posedge clk) begin
        if (rd && wait_req === 1'b0 && notes.size() > 0) begin
            note = notes.pop_front();
            if (note[32]) chk(rdata, note[31:0], "read data");
        end
    end
    initial begin
        void'($urandom(76566));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        chk(mr, 1'b1, "reset not held");
        wait_mr(1'b0);
        bus(0, OFS_CAUSE, 0, {1'b1, 32'h003});
        keep = $urandom & 32'hFFF;
        bus(1, OFS_SCRATCH, keep, 0);
        hw_bits = 12'($urandom);
        bus(1, OFS_CAUSE, {20'h0, hw_bits}, 0);
        repeat (12) @(posedge clk);
        chk(mr, 1'b0, "software set made reset");
        chk(wd_en, hw_bits[BIT_WDOG_SW_ENABLE], "watchdog enable");
        bus(0, OFS_CAUSE, 0, {1'b1, 20'h0, hw_bits});
        for (int i = 0; i < NUM_SRC; i++) begin
            bus(1, OFS_CAUSE, 0, 0);
            src_req_model_inst.fire(i, 3 + $urandom % 3);
            wait_mr(1'b1);
            wait_mr(1'b0);
            bus(0, OFS_CAUSE, 0, {1'b1, 32'h1 << SRC_CAUSE_POS[i]});
        end
        bus(1, 4'hD, ~keep, 0);
        bus(0, 4'h1, 0, {1'b1, 32'h0});
        bus(0, OFS_SCRATCH, 0, {1'b1, keep});
        bus(1, OFS_IRQ_MASK, 32'hFFF, 0);
        repeat (3) @(posedge clk);
        chk(irq, 1'b1, "irq not raised");
        bus(1, OFS_IRQ_MASK, 0, 0);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0, "irq not masked");
        bus(0, OFS_IRQ_STATUS, 0, {1'b1, 32'hFD2});
        bus(0, OFS_IRQ_STATUS, 0, {1'b1, 32'h0});
        bus(1, OFS_CAUSE, 0, 0);
        bus(1, OFS_IRQ_MASK, 32'hFFF, 0);
        wk_i <= 1'b1;
        wk_s <= 1'b1;
        @(posedge clk);
        wk_i <= 1'b0;
        wk_s <= 1'b0;
        repeat (3) @(posedge clk);
        chk(irq, 1'b1, "wake irq");
        bus(0, OFS_IRQ_STATUS, 0, {1'b1, 32'h00C});
        repeat (3) @(posedge clk);
        chk(irq, 1'b0, "irq not cleared");
        bus(0, OFS_CAUSE, 0, {1'b1, 32'h00C});
        bus(1, OFS_CAUSE, 0, 0);
        ce <= 1'b0;
        wk_i <= 1'b1;
        @(posedge clk);
        ce <= 1'b1;
        wk_i <= 1'b0;
        bus(0, OFS_CAUSE, 0, {1'b1, 32'h0});
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wait_mr(1'b0);
        bus(0, OFS_CAUSE, 0, {1'b1, 32'h003});
        end_sim();
    end
endmodule // test_src_top
